// ### inc/rpcu_consts.vh
`ifndef RPCU_CONSTS_VH
`define RPCU_CONSTS_VH

`define RPCU_REG_STATUS     8'h00
`define RPCU_REG_BAUD_DIV   8'h04
`define RPCU_REG_IRQ_STATUS 8'h08
`define RPCU_REG_IRQ_MASK   8'h0c
`define RPCU_REG_LOCATION   8'h10

`define RPCU_BAUD_DIV_RST   16'h00d9

`define RPCU_IRQ_DONE       0
`define RPCU_IRQ_ERROR      1
`define RPCU_IRQ_OVERRUN    2
`define RPCU_IRQ_W          3

`define RPCU_CH_CR          8'h0d
`define RPCU_CH_LF          8'h0a
`define RPCU_CH_SP          8'h20
`define RPCU_CH_BUSY        8'h62
`define RPCU_CH_READY       8'h72
`define RPCU_CH_ERR         8'h65
`define RPCU_CH_ZERO        8'h30
`define RPCU_CH_NINE        8'h39

`define RPCU_CMD_ECHO_0     8'h65
`define RPCU_CMD_ECHO_1     8'h63
`define RPCU_CMD_GOTO_0     8'h67
`define RPCU_CMD_GOTO_1     8'h6c
`define RPCU_CMD_RAISE_0    8'h78
`define RPCU_CMD_RAISE_1    8'h70
`define RPCU_CMD_DROP_0     8'h6c
`define RPCU_CMD_DROP_1     8'h70
`define RPCU_CMD_MDIS_0     8'h73
`define RPCU_CMD_MDIS_1     8'h64
`define RPCU_CMD_SRST_0     8'h73
`define RPCU_CMD_SRST_1     8'h74

`define RPCU_ERR_UNKNOWN    8'h31
`define RPCU_ERR_PARAM      8'h32
`define RPCU_ERR_MOVE_UP    8'h33
`define RPCU_ERR_RAISE_MOV  8'h34

`endif

// ### design/rpcu_top.v
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rpcu_consts.vh"

module rpcu_top #(
	parameter LINE_MAX      = 16,
	parameter PSEL_W        = 3,
	parameter MAX_LOC       = 2047,
	parameter PISTON_CYCLES = 25000,
	parameter SETTLE_CYCLES = 8
) (
	input  wire                    core_clk,
	input  wire                    rstn,
	input  wire [7:0]              avs_address,
	input  wire                    avs_read,
	input  wire                    avs_write,
	input  wire [31:0]             avs_writedata,
	input  wire [3:0]              avs_byteenable,
	output reg  [31:0]             avs_readdata,
	output wire                    avs_waitrequest,
	output wire                    irq,
	input  wire                    ser_rx_pin,
	output wire                    ser_tx_pin,
	input  wire                    platter_in_pos_pin,
	output reg  [10:0]             platter_target,
	output reg                     platter_move,
	output reg                     motor_disable,
	output reg  [(1<<PSEL_W)-1:0]  piston_up
);
	localparam NPIST = 1 << PSEL_W;
	localparam S_RX = 4'd0, S_ECHO = 4'd1, S_LF = 4'd2, S_DEC = 4'd3, S_B = 4'd4, S_BCR = 4'd5;
	localparam S_EXEC = 4'd6, S_FIN1 = 4'd7, S_FIN2 = 4'd8, S_FIN3 = 4'd9;
	localparam OP_NONE = 3'd0, OP_ECHO = 3'd1, OP_GOTO = 3'd2, OP_RAISE = 3'd3, OP_DROP = 3'd4, OP_MDIS = 3'd5;

	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer k;
		begin
			be_merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (be[k])
					be_merge[8*k +: 8] = wd[8*k +: 8];
		end
	endfunction

	// Pin synchronisers: a change counts once stages two and three agree
	reg  [2:0]  rx_sync_reg;
	reg  [2:0]  pos_sync_reg;
	reg         rx_line_reg;
	reg         in_pos_reg;
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rx_sync_reg  <= 3'h7;
			pos_sync_reg <= 3'h0;
			rx_line_reg  <= 1'b1;
			in_pos_reg   <= 1'b0;
		end
		else
		begin
			rx_sync_reg  <= {rx_sync_reg[1:0], ser_rx_pin};
			pos_sync_reg <= {pos_sync_reg[1:0], platter_in_pos_pin};
			if (rx_sync_reg[1] == rx_sync_reg[2])
				rx_line_reg <= rx_sync_reg[2];
			if (pos_sync_reg[1] == pos_sync_reg[2])
				in_pos_reg <= pos_sync_reg[2];
		end
	end

	// Bus registers
	reg  [15:0]            baud_div_reg;
	reg  [`RPCU_IRQ_W-1:0] irq_stat_reg;
	reg  [`RPCU_IRQ_W-1:0] irq_mask_reg;
	reg                    ack_reg;
	wire                   bus_req = avs_read | avs_write;
	wire                   bus_take = bus_req & ~ack_reg;
	wire [`RPCU_IRQ_W-1:0] irq_set;
	reg  [3:0]             state_reg;
	reg                    echo_reg;
	reg  [10:0]            loc_reg;
	reg  [PSEL_W-1:0]      sel_reg;
	reg  [7:0]             err_reg;
	wire [31:0]            baud_merged = be_merge({16'h0, baud_div_reg}, avs_writedata, avs_byteenable);

	assign avs_waitrequest = bus_take;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			ack_reg      <= 1'b0;
			avs_readdata <= 32'h0;
			baud_div_reg <= `RPCU_BAUD_DIV_RST;
			irq_stat_reg <= {`RPCU_IRQ_W{1'b0}};
			irq_mask_reg <= {`RPCU_IRQ_W{1'b0}};
		end
		else
		begin
			ack_reg <= bus_take;
			if (bus_take && avs_read)
			begin
				case ({avs_address[7:2], 2'b00})
					`RPCU_REG_STATUS:     avs_readdata <= {8'h0, err_reg, 4'h0, state_reg, 4'h0,
									in_pos_reg, motor_disable, (state_reg != S_RX), echo_reg};
					`RPCU_REG_BAUD_DIV:   avs_readdata <= {16'h0, baud_div_reg};
					`RPCU_REG_IRQ_STATUS: avs_readdata <= {{(32-`RPCU_IRQ_W){1'b0}}, irq_stat_reg};
					`RPCU_REG_IRQ_MASK:   avs_readdata <= {{(32-`RPCU_IRQ_W){1'b0}}, irq_mask_reg};
					`RPCU_REG_LOCATION:   avs_readdata <= {piston_up, {(8-PSEL_W){1'b0}}, sel_reg,
									5'h0, loc_reg};
					default:              avs_readdata <= 32'h0;
				endcase
			end
			if (bus_take && avs_write && {avs_address[7:2], 2'b00} == `RPCU_REG_BAUD_DIV)
				baud_div_reg <= baud_merged[15:0];
			if (bus_take && avs_write && {avs_address[7:2], 2'b00} == `RPCU_REG_IRQ_MASK && avs_byteenable[0])
				irq_mask_reg <= avs_writedata[`RPCU_IRQ_W-1:0];
			// Set beats a simultaneous write-one clear
			if (bus_take && avs_write && {avs_address[7:2], 2'b00} == `RPCU_REG_IRQ_STATUS && avs_byteenable[0])
				irq_stat_reg <= (irq_stat_reg & ~avs_writedata[`RPCU_IRQ_W-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	// Serial receiver, 8N1, one bit lasts the divisor plus one core_clk cycles
	reg  [15:0] rx_cnt_reg;
	reg  [3:0]  rx_bit_reg;
	reg  [7:0]  rx_shift_reg;
	reg         rx_busy_reg;
	reg         rx_valid_reg;
	reg  [7:0]  rx_data_reg;
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rx_cnt_reg   <= 16'h0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 8'h0;
			rx_busy_reg  <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_data_reg  <= 8'h0;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			if (!rx_busy_reg)
			begin
				if (!rx_line_reg)
				begin
					rx_busy_reg <= 1'b1;
					rx_bit_reg  <= 4'h0;
					rx_cnt_reg  <= {1'b0, baud_div_reg[15:1]};
				end
			end
			else if (rx_cnt_reg != 16'h0)
				rx_cnt_reg <= rx_cnt_reg - 16'h1;
			else
			begin
				rx_cnt_reg <= baud_div_reg;
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0 && rx_line_reg)
					rx_busy_reg <= 1'b0;  // Glitch, not a start bit
				else if (rx_bit_reg == 4'h9)
				begin
					rx_busy_reg  <= 1'b0;
					rx_valid_reg <= rx_line_reg;  // Framing error drops the byte
					rx_data_reg  <= rx_shift_reg;
				end
				else if (rx_bit_reg != 4'h0)
					rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
			end
		end
	end

	// Serial transmitter
	reg  [9:0]  tx_shift_reg;
	reg  [3:0]  tx_bit_reg;
	reg  [15:0] tx_cnt_reg;
	reg         tx_busy_reg;
	reg         tx_go_reg;
	reg  [7:0]  tx_data_reg;
	assign ser_tx_pin = tx_shift_reg[0];
	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			tx_shift_reg <= 10'h3ff;
			tx_bit_reg   <= 4'h0;
			tx_cnt_reg   <= 16'h0;
			tx_busy_reg  <= 1'b0;
		end
		else if (!tx_busy_reg)
		begin
			if (tx_go_reg)
			begin
				tx_shift_reg <= {1'b1, tx_data_reg, 1'b0};
				tx_busy_reg  <= 1'b1;
				tx_bit_reg   <= 4'h0;
				tx_cnt_reg   <= baud_div_reg;
			end
		end
		else if (tx_cnt_reg != 16'h0)
			tx_cnt_reg <= tx_cnt_reg - 16'h1;
		else
		begin
			tx_cnt_reg   <= baud_div_reg;
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			tx_bit_reg   <= tx_bit_reg + 4'h1;
			if (tx_bit_reg == 4'h9)
				tx_busy_reg <= 1'b0;
		end
	end

	// Command line store and incremental argument parse
	reg  [7:0]  line_mem [0:LINE_MAX-1];
	reg  [4:0]  len_reg;
	reg  [4:0]  idx_reg;
	reg  [11:0] num_reg;
	reg         has_arg_reg;
	reg         bad_arg_reg;
	reg         too_long_reg;
	reg  [2:0]  op_reg;
	reg  [23:0] wait_reg;
	reg         resp_err_reg;
	wire [7:0]  rx_ch = rx_data_reg;
	wire        rx_digit = rx_ch >= `RPCU_CH_ZERO && rx_ch <= `RPCU_CH_NINE;
	wire        send_ok = !tx_busy_reg && !tx_go_reg;
	wire [7:0]  c0 = line_mem[0];
	wire [7:0]  c1 = line_mem[1];
	wire        arg_bit = has_arg_reg && !bad_arg_reg && num_reg < 12'd2;
	reg  [7:0]  out_ch;

	assign irq_set[`RPCU_IRQ_DONE]    = send_ok && state_reg == S_FIN3;
	assign irq_set[`RPCU_IRQ_ERROR]   = send_ok && state_reg == S_FIN1 && resp_err_reg;
	assign irq_set[`RPCU_IRQ_OVERRUN] = rx_valid_reg && state_reg != S_RX;

	always @*
	begin
		case (state_reg)
			S_ECHO:  out_ch = line_mem[idx_reg[3:0]];
			S_LF:    out_ch = `RPCU_CH_LF;
			S_B:     out_ch = `RPCU_CH_BUSY;
			S_FIN1:  out_ch = resp_err_reg ? `RPCU_CH_ERR : `RPCU_CH_READY;
			S_FIN2:  out_ch = err_reg;
			default: out_ch = `RPCU_CH_CR;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_reg      <= S_RX;
			tx_go_reg      <= 1'b0;
			tx_data_reg    <= 8'h0;
			len_reg        <= 5'h0;
			idx_reg        <= 5'h0;
			num_reg        <= 12'h0;
			has_arg_reg    <= 1'b0;
			bad_arg_reg    <= 1'b0;
			too_long_reg   <= 1'b0;
			op_reg         <= OP_NONE;
			wait_reg       <= 24'h0;
			resp_err_reg   <= 1'b0;
			err_reg        <= 8'h0;
			echo_reg       <= 1'b0;
			loc_reg        <= 11'h0;
			sel_reg        <= {PSEL_W{1'b0}};
			platter_target <= 11'h0;
			platter_move   <= 1'b0;
			motor_disable  <= 1'b0;
			piston_up      <= {NPIST{1'b0}};
		end
		else
		begin
			tx_go_reg    <= 1'b0;
			platter_move <= 1'b0;
			case (state_reg)
				S_RX:
				if (rx_valid_reg)
				begin
					if (len_reg < LINE_MAX)
						line_mem[len_reg[3:0]] <= rx_ch;
					else
						too_long_reg <= 1'b1;
					if (len_reg != 5'h1f)
						len_reg <= len_reg + 5'h1;
					if (rx_ch == `RPCU_CH_CR)
					begin
						idx_reg   <= 5'h0;
						state_reg <= echo_reg ? S_ECHO : S_DEC;
					end
					else if (len_reg >= 5'h2)
					begin
						if (rx_digit)
						begin
							has_arg_reg <= 1'b1;
							// Stop before ten times plus a digit wraps the 12-bit value
							if (num_reg > 12'd408)
								bad_arg_reg <= 1'b1;
							else
								num_reg <= num_reg * 12'd10 + {4'h0, rx_ch - `RPCU_CH_ZERO};
						end
						else if (rx_ch != `RPCU_CH_SP)
							bad_arg_reg <= 1'b1;
					end
				end
				S_ECHO:
				if (send_ok)
				begin
					tx_go_reg   <= 1'b1;
					tx_data_reg <= out_ch;
					idx_reg     <= idx_reg + 5'h1;
					if (idx_reg + 5'h1 >= len_reg || idx_reg + 5'h1 >= LINE_MAX)
						state_reg <= S_LF;
				end
				S_DEC:
				begin
					resp_err_reg <= 1'b1;
					state_reg    <= S_FIN1;
					op_reg       <= OP_NONE;
					if (too_long_reg || len_reg < 5'h3)
						err_reg <= `RPCU_ERR_UNKNOWN;
					else if (c0 == `RPCU_CMD_SRST_0 && c1 == `RPCU_CMD_SRST_1)
					begin
						resp_err_reg  <= 1'b0;
						echo_reg      <= 1'b0;
						motor_disable <= 1'b1;
						loc_reg       <= 11'h0;
						sel_reg       <= {PSEL_W{1'b0}};
						piston_up     <= {NPIST{1'b0}};
					end
					else if ((c0 == `RPCU_CMD_ECHO_0 && c1 == `RPCU_CMD_ECHO_1)
						|| (c0 == `RPCU_CMD_MDIS_0 && c1 == `RPCU_CMD_MDIS_1))
					begin
						if (!arg_bit)
							err_reg <= `RPCU_ERR_PARAM;
						else
						begin
							op_reg    <= (c0 == `RPCU_CMD_ECHO_0) ? OP_ECHO : OP_MDIS;
							state_reg <= S_B;
						end
					end
					else if (c0 == `RPCU_CMD_GOTO_0 && c1 == `RPCU_CMD_GOTO_1)
					begin
						if (!has_arg_reg || bad_arg_reg || num_reg > MAX_LOC)
							err_reg <= `RPCU_ERR_PARAM;
						else if (|piston_up)
							err_reg <= `RPCU_ERR_MOVE_UP;
						else
						begin
							op_reg    <= OP_GOTO;
							state_reg <= S_B;
						end
					end
					else if (c0 == `RPCU_CMD_RAISE_0 && c1 == `RPCU_CMD_RAISE_1)
					begin
						if (!in_pos_reg)
							err_reg <= `RPCU_ERR_RAISE_MOV;
						else
						begin
							op_reg    <= OP_RAISE;
							state_reg <= S_B;
						end
					end
					else if (c0 == `RPCU_CMD_DROP_0 && c1 == `RPCU_CMD_DROP_1)
					begin
						op_reg    <= OP_DROP;
						state_reg <= S_B;
					end
					else
						err_reg <= `RPCU_ERR_UNKNOWN;
				end
				S_EXEC:
				begin
					if (wait_reg != 24'h0)
						wait_reg <= wait_reg - 24'h1;
					// Settle time covers the pin synchroniser latency after a move start
					else if (op_reg != OP_GOTO || in_pos_reg)
					begin
						resp_err_reg <= 1'b0;
						state_reg    <= S_FIN1;
						if (op_reg == OP_RAISE)
							piston_up[sel_reg] <= 1'b1;
						if (op_reg == OP_DROP)
							piston_up[sel_reg] <= 1'b0;
					end
				end
				default:
				if (send_ok)
				begin
					tx_go_reg   <= 1'b1;
					tx_data_reg <= out_ch;
					case (state_reg)
						S_LF:   state_reg <= S_DEC;
						S_B:    state_reg <= S_BCR;
						S_FIN1: state_reg <= resp_err_reg ? S_FIN2 : S_FIN3;
						S_FIN2: state_reg <= S_FIN3;
						S_BCR:
						begin
							state_reg <= S_EXEC;
							wait_reg  <= 24'h0;
							case (op_reg)
								OP_ECHO: echo_reg <= num_reg[0];
								OP_MDIS: motor_disable <= num_reg[0];
								OP_GOTO:
								begin
									loc_reg        <= num_reg[10:0];
									sel_reg        <= num_reg[PSEL_W-1:0];
									platter_target <= num_reg[10:0];
									platter_move   <= 1'b1;
									wait_reg       <= SETTLE_CYCLES[23:0];
								end
								default: wait_reg <= PISTON_CYCLES[23:0];
							endcase
						end
						default:
						begin
							state_reg    <= S_RX;
							len_reg      <= 5'h0;
							num_reg      <= 12'h0;
							has_arg_reg  <= 1'b0;
							bad_arg_reg  <= 1'b0;
							too_long_reg <= 1'b0;
						end
					endcase
				end
			endcase
		end
	end
endmodule // rpcu_top
`default_nettype wire

// ### verification/rpcu_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rpcu_checker #(
	parameter MAX_LOC = 2047,
	parameter PSEL_W  = 3
) (
	input wire logic                   core_clk,
	input wire logic                   rstn,
	input wire logic                   avs_read,
	input wire logic                   avs_write,
	input wire logic                   avs_waitrequest,
	input wire logic                   ser_tx_pin,
	input wire logic [10:0]            platter_target,
	input wire logic                   platter_move,
	input wire logic                   motor_disable,
	input wire logic [(1<<PSEL_W)-1:0] piston_up
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_ONE_WAIT: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus access not one wait state");
	AST_IDLE_NO_WAIT: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("waitrequest while idle");
	AST_RESET_STATE: assert property (!$past(rstn) |-> ser_tx_pin && !motor_disable && piston_up == 0 && !platter_move)
		else $error("outputs not idle after reset");
	AST_MOVE_PULSE: assert property (platter_move |=> !platter_move [*8])
		else $error("move pulse too long");
	AST_MOVE_DOWN: assert property (platter_move |-> piston_up == 0)
		else $error("move with piston raised");
	AST_TARGET_RANGE: assert property (platter_move |-> platter_target <= MAX_LOC)
		else $error("target out of range");
	AST_ONE_PISTON: assert property ($changed(piston_up) |-> $onehot(piston_up ^ $past(piston_up)))
		else $error("several pistons changed");
	AST_PISTON_STILL: assert property ($changed(piston_up) |-> !platter_move && !$past(platter_move))
		else $error("piston moved with platter");
endmodule // rpcu_checker
`default_nettype wire

// ### verification/rpcu_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rpcu_host_model #(
	parameter BIT = 8
) (
	input  wire logic core_clk,
	output var  logic rx,
	input  wire logic tx
);
	logic [7:0] rxq[$];
	int         gap = 0;
	initial rx = 1'b1;
	task automatic put(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rx <= f[i];
			repeat (BIT) @(posedge core_clk);
		end
		repeat (gap) @(posedge core_clk);
	endtask
	// Caller waits for the answer before the next line
	task automatic send(input string s);
		foreach (s[i])
			put(s[i]);
		put(8'h0d);
	endtask
	// Mid-bit sampling keeps clear of the edges
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(negedge tx);
			repeat (BIT / 2) @(posedge core_clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT) @(posedge core_clk);
				b[i] = tx;
			end
			repeat (BIT) @(posedge core_clk);
			rxq.push_back(b);
		end
	end
endmodule // rpcu_host_model
`default_nettype wire

// ### verification/rotary_platter_command_unit_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rpcu_consts.vh"
module rotary_platter_command_unit_tb_top;
	localparam BIT = 8;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        ser_rx_pin;
	logic        ser_tx_pin;
	logic        platter_move;
	logic        motor_disable;
	logic [10:0] platter_target;
	logic [7:0]  piston_up;
	logic        in_pos = 1'b1;
	logic        hold_moving = 1'b0;
	logic [31:0] rd;
	int          mv_cnt = 0;
	int          moves = 0;
	int          miscompares = 0;
	int          comparisons = 0;
	always #20 core_clk = ~core_clk;
	rpcu_top #(.PISTON_CYCLES(20)) dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .ser_rx_pin(ser_rx_pin),
		.ser_tx_pin(ser_tx_pin), .platter_in_pos_pin(in_pos), .platter_target(platter_target),
		.platter_move(platter_move), .motor_disable(motor_disable), .piston_up(piston_up));
	rpcu_host_model #(.BIT(BIT)) host (.core_clk(core_clk), .rx(ser_rx_pin), .tx(ser_tx_pin));
	// Platter stand-in: off position for 31 cycles per move
	always @(posedge core_clk)
		if (platter_move)
		begin
			in_pos <= 1'b0;
			mv_cnt <= 30;
			moves  <= moves + 1;
		end
		else if (mv_cnt != 0)
			mv_cnt <= mv_cnt - 1;
		else
			in_pos <= !hold_moving;
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest && n < 50);
		if (n >= 50)
			miscompares++;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	// Bar stands for CR, tilde for LF
	function automatic logic [127:0] pk(input string s);
		logic [127:0] v;
		v = '0;
		foreach (s[i])
			v = {v[119:0], s[i] == "|" ? 8'h0d : s[i] == "~" ? 8'h0a : 8'(s[i])};
		return v;
	endfunction
	task automatic cmd(input string c, input string e);
		logic [127:0] v;
		int n;
		v = '0;
		n = 0;
		host.rxq.delete();
		host.send(c);
		while (host.rxq.size() < e.len() && n < 4000)
		begin
			@(posedge core_clk);
			n++;
		end
		// Extra time so stray trailing chars show up
		repeat (30 * BIT) @(posedge core_clk);
		for (int i = 0; i < host.rxq.size(); i++)
			v = {v[119:0], host.rxq[i]};
		chk(v, pk(e));
	endtask
	task automatic t_regs;
		av(1'b0, `RPCU_REG_BAUD_DIV, 32'h0);
		chk(rd, 32'h0000_00d9);
		av(1'b1, `RPCU_REG_BAUD_DIV, 32'(BIT - 1));
		av(1'b0, `RPCU_REG_BAUD_DIV, 32'h0);
		chk(rd, 32'(BIT - 1));
		av(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		av(1'b0, `RPCU_REG_STATUS, 32'h0);
		chk(rd[0], 1'b0);
		$display("test regs done");
	endtask
	task automatic t_echo;
		cmd("sd 0", "b|r|");
		cmd("ec 1", "b|r|");
		cmd("sd 0", "sd 0|~b|r|");
		cmd("ec 0", "ec 0|~b|r|");
		cmd("sd 0", "b|r|");
		$display("test echo done");
	endtask
	task automatic t_goto;
		host.gap = 40;
		cmd("gl 5", "b|r|");
		chk(platter_target, 11'd5);
		chk(moves, 1);
		host.gap = 0;
		cmd("xp", "b|r|");
		chk(piston_up, 8'h20);
		cmd("gl 3", "e3|");
		cmd("lp", "b|r|");
		chk(piston_up, 8'h00);
		cmd("gl 2047", "b|r|");
		chk(platter_target, 11'd2047);
		av(1'b0, `RPCU_REG_LOCATION, 32'h0);
		chk(rd, 32'h0007_07ff);
		cmd("gl 2048", "e2|");
		cmd("gl 4096", "e2|");
		chk(moves, 2);
		chk(irq, 1'b0);
		$display("test goto done");
	endtask
	task automatic t_errs;
		cmd("zz", "e1|");
		hold_moving <= 1'b1;
		repeat (10) @(posedge core_clk);
		cmd("xp", "e4|");
		chk(piston_up, 8'h00);
		hold_moving <= 1'b0;
		repeat (10) @(posedge core_clk);
		$display("test errors done");
	endtask
	task automatic t_mdis;
		av(1'b1, `RPCU_REG_IRQ_STATUS, 32'h7);
		av(1'b1, `RPCU_REG_IRQ_MASK, 32'h1);
		cmd("sd 1", "b|r|");
		chk(motor_disable, 1'b1);
		chk(irq, 1'b1);
		av(1'b1, `RPCU_REG_IRQ_STATUS, 32'h1);
		chk(irq, 1'b0);
		cmd("sd 0", "b|r|");
		chk(motor_disable, 1'b0);
		cmd("ec 1", "b|r|");
		cmd("st", "st|~r|");
		chk(motor_disable, 1'b1);
		cmd("sd 0", "b|r|");
		$display("test motor done");
	endtask
	task automatic test_done;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_echo;
		t_goto;
		t_errs;
		t_mdis;
		test_done;
	end
	initial
	begin
		repeat (90000) @(posedge core_clk);
		miscompares++;
		test_done;
	end
endmodule // rotary_platter_command_unit_tb_top
bind rpcu_top rpcu_checker #(.MAX_LOC(MAX_LOC), .PSEL_W(PSEL_W)) u_chk (.core_clk(core_clk), .rstn(rstn),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ser_tx_pin(ser_tx_pin),
	.platter_target(platter_target), .platter_move(platter_move), .motor_disable(motor_disable),
	.piston_up(piston_up));
`default_nettype wire
